/* File: design/rcd_flag_bank.sv */
`timescale 1ns/1ns
module rcd_flag_bank #(
   parameter int unsigned WIDTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] set_in,
   input wire logic clr_wr,
   input wire logic [WIDTH-1:0] clr_data,
   output logic [WIDTH-1:0] flags
);
   import rcd_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } rcd_flag_state_t;

   rcd_flag_state_t state_reg;
   rcd_flag_state_t state_next;

   // ------------------------------------------------------------
   // sticky flags, write 0 clears, set beats clear
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (clr_wr) begin
         state_next.flags = state_reg.flags & clr_data;
      end
      state_next.flags = state_next.flags | set_in;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign flags = state_reg.flags;
endmodule // rcd_flag_bank

/* File: design/rcd_irq_router.sv */
`timescale 1ns/1ns
module rcd_irq_router #(
   parameter int unsigned ENG_W = 32,
   parameter int unsigned HW_W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ENG_W-1:0] eng_flags,
   input wire logic [ENG_W-1:0] eng_enable,
   input wire logic [ENG_W-1:0] eng_select,
   input wire logic [HW_W-1:0] hw_flags,
   input wire logic [HW_W-1:0] hw_enable,
   input wire logic ack_flag,
   output logic engine_irq_line_a,
   output logic engine_irq_line_b,
   output logic hardware_irq_line,
   output logic ack_irq_line
);
   import rcd_pkg::*;

   typedef struct packed {
      logic line_a;
      logic line_b;
      logic line_hw;
      logic line_ack;
   } rcd_irq_state_t;

   rcd_irq_state_t state_reg;
   rcd_irq_state_t state_next;
   logic [ENG_W-1:0] eng_active;

   // ------------------------------------------------------------
   // level lines from flag and enable; ack line from its flag alone
   // ------------------------------------------------------------
   assign eng_active = eng_flags & eng_enable;

   always_comb begin
      state_next = state_reg;
      state_next.line_a = |(eng_active & ~eng_select);
      state_next.line_b = |(eng_active & eng_select);
      state_next.line_hw = |(hw_flags & hw_enable);
      state_next.line_ack = ack_flag;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign engine_irq_line_a = state_reg.line_a;
   assign engine_irq_line_b = state_reg.line_b;
   assign hardware_irq_line = state_reg.line_hw;
   assign ack_irq_line = state_reg.line_ack;
endmodule // rcd_irq_router

/* File: design/rcd_pkg.sv */
package rcd_pkg;

   // ------------------------------------------------------------
   // bus and register map
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   localparam logic [ADDR_W-1:0] OFS_COMMAND_MAILBOX = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_COMMAND_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_ENGINE_IRQ_FLAGS = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_ENGINE_IRQ_ENABLE = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_ENGINE_LINE_SELECT = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_HW_IRQ_FLAGS = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_HW_IRQ_ENABLE = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_ACK_FLAG_REGISTER = 12'h01c;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int unsigned ENGINE_SRC_W = 32;
   localparam int unsigned HW_SRC_W = 32;
   localparam int unsigned ACK_FLAG_BIT = 0;
   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

   // host interrupt numbers of the four lines
   localparam int unsigned IRQ_NUM_ENGINE_A = 9;
   localparam int unsigned IRQ_NUM_ENGINE_B = 2;
   localparam int unsigned IRQ_NUM_HARDWARE = 10;
   localparam int unsigned IRQ_NUM_ACK = 11;

   // ------------------------------------------------------------
   // apb slave phase
   // ------------------------------------------------------------
   typedef enum logic [0:0] {
      RCD_APB_WAIT = 1'b0,
      RCD_APB_DONE = 1'b1
   } rcd_apb_phase_t;

endpackage

/* File: design/rcd_radio_doorbell.sv */
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// - mailbox takes a write only while it holds zero, else write dropped
// - accepted nonzero write notifies radio side and zeroes command status
// - mailbox reads the written word until radio marks it done, then zero
// - status is read-only, loaded with radio status as mailbox returns to zero
// - completion sets the ack flag; ack line stays high while flag is set
// - four host lines: engine a (9), engine b (2), hardware (10), ack (11)
// - each engine source goes to line a or b by its select bit
// - engine source event sets its sticky flag until software clears it
// - engine line raised while any flag and matching enable are both set
// - engine flag write clears bits written 0, keeps bits written 1
// - hardware event sets its flag; hardware line while flag and enable set
// - hardware flag write clears bits written 0, keeps bits written 1
module rcd_radio_doorbell #(
   parameter int unsigned ENG_W = rcd_pkg::ENGINE_SRC_W,
   parameter int unsigned HW_W = rcd_pkg::HW_SRC_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rcd_pkg::ADDR_W-1:0] paddr,
   input wire logic [rcd_pkg::DATA_W-1:0] pwdata,
   output logic [rcd_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic cmd_notify,
   output logic cmd_pending,
   output logic [rcd_pkg::DATA_W-1:0] cmd_word,
   input wire logic cmd_done,
   input wire logic [rcd_pkg::DATA_W-1:0] cmd_done_status,
   input wire logic [ENG_W-1:0] engine_event,
   input wire logic [HW_W-1:0] hw_event,
   output logic engine_irq_line_a,
   output logic engine_irq_line_b,
   output logic hardware_irq_line,
   output logic ack_irq_line
);
   import rcd_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      rcd_apb_phase_t phase;
      logic [DATA_W-1:0] prdata;
      logic pslverr;
      logic [DATA_W-1:0] command_mailbox;
      logic [DATA_W-1:0] command_status;
      logic [ENG_W-1:0] engine_irq_enable;
      logic [ENG_W-1:0] engine_line_select;
      logic [HW_W-1:0] hw_irq_enable;
      logic cmd_notify;
      logic cmd_pending;
   } rcd_db_state_t;

   rcd_db_state_t state_reg;
   rcd_db_state_t state_next;

   logic [ENG_W-1:0] engine_irq_flags;
   logic [HW_W-1:0] hw_irq_flags;
   logic [0:0] ack_flag_register;

   logic access;
   logic commit;
   logic wr_commit;
   logic mapped;
   logic [DATA_W-1:0] rd_word;
   logic wr_engine_flags;
   logic wr_hw_flags;
   logic wr_ack_flag;
   logic cmd_complete;
   logic [0:0] ack_set;

   // ------------------------------------------------------------
   // apb handshake: one wait cycle, data and pready from flops
   // ------------------------------------------------------------
   assign access = psel && penable;
   assign commit = access && (state_reg.phase == RCD_APB_DONE);
   assign wr_commit = commit && pwrite;

   // ------------------------------------------------------------
   // address decode and read mux
   // ------------------------------------------------------------
   always_comb begin
      mapped = 1'b1;
      rd_word = WORD_ZERO;
      if (paddr == OFS_COMMAND_MAILBOX) begin
         rd_word = state_reg.command_mailbox;
      end else if (paddr == OFS_COMMAND_STATUS) begin
         rd_word = state_reg.command_status;
      end else if (paddr == OFS_ENGINE_IRQ_FLAGS) begin
         rd_word[ENG_W-1:0] = engine_irq_flags;
      end else if (paddr == OFS_ENGINE_IRQ_ENABLE) begin
         rd_word[ENG_W-1:0] = state_reg.engine_irq_enable;
      end else if (paddr == OFS_ENGINE_LINE_SELECT) begin
         rd_word[ENG_W-1:0] = state_reg.engine_line_select;
      end else if (paddr == OFS_HW_IRQ_FLAGS) begin
         rd_word[HW_W-1:0] = hw_irq_flags;
      end else if (paddr == OFS_HW_IRQ_ENABLE) begin
         rd_word[HW_W-1:0] = state_reg.hw_irq_enable;
      end else if (paddr == OFS_ACK_FLAG_REGISTER) begin
         rd_word[ACK_FLAG_BIT] = ack_flag_register[0];
      end else begin
         mapped = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // flag clear strobes
   // ------------------------------------------------------------
   assign wr_engine_flags = wr_commit && (paddr == OFS_ENGINE_IRQ_FLAGS);
   assign wr_hw_flags = wr_commit && (paddr == OFS_HW_IRQ_FLAGS);
   assign wr_ack_flag = wr_commit && (paddr == OFS_ACK_FLAG_REGISTER);

   // radio completion only counts while a command is held
   assign cmd_complete = cmd_done && (state_reg.command_mailbox != WORD_ZERO);
   assign ack_set = cmd_complete ? 1'b1 : 1'b0;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.cmd_notify = 1'b0;

      case (state_reg.phase)
         RCD_APB_WAIT: begin
            if (access) begin
               state_next.phase = RCD_APB_DONE;
               state_next.prdata = pwrite ? WORD_ZERO : rd_word;
               state_next.pslverr = ~mapped;
            end
         end
         RCD_APB_DONE: begin
            state_next.phase = RCD_APB_WAIT;
            state_next.prdata = WORD_ZERO;
            state_next.pslverr = 1'b0;
         end
         default: begin
            state_next.phase = RCD_APB_WAIT;
         end
      endcase

      if (wr_commit) begin
         if (paddr == OFS_COMMAND_MAILBOX) begin
            if ((state_reg.command_mailbox == WORD_ZERO) && (pwdata != WORD_ZERO)) begin
               state_next.command_mailbox = pwdata;
               state_next.command_status = WORD_ZERO;
               state_next.cmd_notify = 1'b1;
            end
         end else if (paddr == OFS_ENGINE_IRQ_ENABLE) begin
            state_next.engine_irq_enable = pwdata[ENG_W-1:0];
         end else if (paddr == OFS_ENGINE_LINE_SELECT) begin
            state_next.engine_line_select = pwdata[ENG_W-1:0];
         end else if (paddr == OFS_HW_IRQ_ENABLE) begin
            state_next.hw_irq_enable = pwdata[HW_W-1:0];
         end
      end

      // mailbox is nonzero here, so a same-cycle write was dropped above
      if (cmd_complete) begin
         state_next.command_mailbox = WORD_ZERO;
         state_next.command_status = cmd_done_status;
      end

      // pending level registered so the radio side sees it straight from a flop
      state_next.cmd_pending = (state_next.command_mailbox != WORD_ZERO);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.phase <= RCD_APB_WAIT;
         state_reg.command_mailbox <= RST_WORD;
         state_reg.command_status <= RST_WORD;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // sticky flag banks
   // ------------------------------------------------------------
   rcd_flag_bank #(
      .WIDTH(ENG_W)
   ) u_engine_flags (
      .clk(clk),
      .rst(rst),
      .set_in(engine_event),
      .clr_wr(wr_engine_flags),
      .clr_data(pwdata[ENG_W-1:0]),
      .flags(engine_irq_flags)
   );

   rcd_flag_bank #(
      .WIDTH(HW_W)
   ) u_hw_flags (
      .clk(clk),
      .rst(rst),
      .set_in(hw_event),
      .clr_wr(wr_hw_flags),
      .clr_data(pwdata[HW_W-1:0]),
      .flags(hw_irq_flags)
   );

   rcd_flag_bank #(
      .WIDTH(1)
   ) u_ack_flag (
      .clk(clk),
      .rst(rst),
      .set_in(ack_set),
      .clr_wr(wr_ack_flag),
      .clr_data(pwdata[ACK_FLAG_BIT]),
      .flags(ack_flag_register)
   );

   // ------------------------------------------------------------
   // host interrupt lines
   // ------------------------------------------------------------
   rcd_irq_router #(
      .ENG_W(ENG_W),
      .HW_W(HW_W)
   ) u_irq_router (
      .clk(clk),
      .rst(rst),
      .eng_flags(engine_irq_flags),
      .eng_enable(state_reg.engine_irq_enable),
      .eng_select(state_reg.engine_line_select),
      .hw_flags(hw_irq_flags),
      .hw_enable(state_reg.hw_irq_enable),
      .ack_flag(ack_flag_register[0]),
      .engine_irq_line_a(engine_irq_line_a),
      .engine_irq_line_b(engine_irq_line_b),
      .hardware_irq_line(hardware_irq_line),
      .ack_irq_line(ack_irq_line)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata = state_reg.prdata;
   assign pready = (state_reg.phase == RCD_APB_DONE);
   assign pslverr = state_reg.pslverr;
   assign cmd_notify = state_reg.cmd_notify;
   assign cmd_word = state_reg.command_mailbox;
   assign cmd_pending = state_reg.cmd_pending;

endmodule // rcd_radio_doorbell

/* File: testbench/rcd_doorbell_props.sv */
`timescale 1ns/1ns
module rcd_doorbell_props #(
   parameter int unsigned ENG_W = 32,
   parameter int unsigned HW_W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rcd_pkg::ADDR_W-1:0] paddr,
   input wire logic [rcd_pkg::DATA_W-1:0] pwdata,
   input wire logic pready,
   input wire logic cmd_notify,
   input wire logic cmd_pending,
   input wire logic [rcd_pkg::DATA_W-1:0] cmd_word,
   input wire logic cmd_done,
   input wire logic [ENG_W-1:0] engine_event,
   input wire logic engine_irq_line_a,
   input wire logic ack_irq_line
);
   import rcd_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic wr = psel && pwrite;
   wire logic acc = wr && penable && pready && paddr == OFS_COMMAND_MAILBOX;
   sequence s_done;
      !cmd_pending ##1 ack_irq_line;
   endsequence
   chk_mbox_take:
   assert property (acc && pwdata != WORD_ZERO && !cmd_pending
      |=> cmd_notify && cmd_word == $past(pwdata)) else $error("mailbox write lost");
   chk_mbox_drop:
   assert property (acc && cmd_pending && !cmd_done |=> !cmd_notify && $stable(cmd_word))
      else $error("mailbox overwritten");
   chk_mbox_hold:
   assert property (cmd_pending && !cmd_done |=> $stable(cmd_word)) else $error("word moved");
   chk_done_ack:
   assert property (cmd_pending && cmd_done |=> s_done) else $error("no ack after done");
   chk_ack_level:
   assert property (ack_irq_line && !wr && !$past(wr) |=> ack_irq_line)
      else $error("ack line dropped");
   chk_eng_level:
   assert property (engine_irq_line_a && !wr && !$past(wr) |=> engine_irq_line_a)
      else $error("engine line dropped");
   chk_eng_cause:
   assert property ($rose(engine_irq_line_a) |-> $past(|engine_event, 2) || $past(wr, 2))
      else $error("engine line without cause");
   chk_notify_pulse:
   assert property (cmd_notify |=> !cmd_notify) else $error("notify too long");
   chk_reset_quiet:
   assert property (disable iff (1'h0) rst |=> !engine_irq_line_a && !ack_irq_line
      && cmd_word == WORD_ZERO) else $error("reset left state");
   chk_apb_wait:
   assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("bus answer timing");
endmodule // rcd_doorbell_props

/* File: testbench/rcd_radio_model.sv */
`timescale 1ns/1ns
module rcd_radio_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_notify,
   input wire logic [rcd_pkg::DATA_W-1:0] cmd_word,
   input wire logic [7:0] delay,
   output logic cmd_done,
   output logic [rcd_pkg::DATA_W-1:0] cmd_done_status
);
   import rcd_pkg::*;
   logic [7:0] cnt_reg;
   logic busy_reg;
   logic [DATA_W-1:0] last_reg = WORD_ZERO;
   // status bus shows no stale value outside a completion
   always @(posedge clk) begin
      cmd_done <= 1'h0;
      cmd_done_status <= ~last_reg;
      if (rst) begin
         busy_reg <= 1'h0;
      end else if (cmd_notify) begin
         busy_reg <= 1'h1;
         cnt_reg <= delay;
      end else if (busy_reg && cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end else if (busy_reg) begin
         busy_reg <= 1'h0;
         cmd_done <= 1'h1;
         cmd_done_status <= cmd_word | 32'h0000_0001;
         last_reg <= cmd_word | 32'h0000_0001;
      end
   end
endmodule // rcd_radio_model

/* File: testbench/test_radio_command_doorbell.sv */
`timescale 1ns/1ns
module test_radio_command_doorbell;
   import rcd_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [ADDR_W-1:0] paddr = 12'h000;
   logic [DATA_W-1:0] pwdata = 32'h0, prdata, cmd_word, cmd_done_status, r;
   logic pready, pslverr, cmd_notify, cmd_pending, cmd_done;
   logic l_a, l_b, l_hw, l_ack;
   logic [31:0] engine_event = 32'h0, hw_event = 32'h0;
   logic [7:0] delay = 8'h00;
   logic [32:0] notes[$];
   integer mismatches = 0, checks_done = 0, seed = 88284, n;
   wire logic [3:0] lines = {l_a, l_b, l_hw, l_ack};
   always #4 clk = ~clk;
   rcd_radio_doorbell rcd_radio_doorbell_i (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmd_notify(cmd_notify), .cmd_pending(cmd_pending),
      .cmd_word(cmd_word), .cmd_done(cmd_done), .cmd_done_status(cmd_done_status),
      .engine_event(engine_event), .hw_event(hw_event), .engine_irq_line_a(l_a),
      .engine_irq_line_b(l_b), .hardware_irq_line(l_hw), .ack_irq_line(l_ack));
   rcd_radio_model rcd_radio_model_i (.clk(clk), .rst(rst), .cmd_notify(cmd_notify),
      .cmd_word(cmd_word), .delay(delay), .cmd_done(cmd_done),
      .cmd_done_status(cmd_done_status));
   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // one bus transfer; the expected {pslverr, prdata} goes to the monitor
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
         input logic [32:0] exp);
      notes.push_back(exp);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'h1) break;
      end
      if (n == 20) begin
         mismatches++;
         print_verdict();
      end
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'h1, d, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'h0, 32'h0, {1'h0, e});
   endtask
   task automatic pulse(input logic [31:0] e, input logic [31:0] h);
      engine_event <= e;
      hw_event <= h;
      @(posedge clk);
      engine_event <= 32'h0;
      hw_event <= 32'h0;
      repeat (3) @(posedge clk);
   endtask
   task automatic wait_ack();
      for (n = 0; n < 100 && l_ack !== 1'h1; n++) @(posedge clk);
      if (n == 100) begin
         mismatches++;
         print_verdict();
      end
   endtask
   always @(posedge clk) begin
      if (psel && penable && pready === 1'h1) check("apb", {pslverr, prdata}, notes.pop_front());
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      for (int i = 0; i < 8; i++) rd(ADDR_W'(4 * i), WORD_ZERO);
      apb(12'h020, 1'h0, 32'h0, {1'h1, 32'h0});
      check("lines", lines, 4'h0);
      $display("reset test done");
      delay <= 8'h14;
      wr(OFS_COMMAND_MAILBOX, 32'h0042_0701);
      rd(OFS_COMMAND_STATUS, WORD_ZERO);
      wr(OFS_COMMAND_MAILBOX, 32'h0000_1a40);
      rd(OFS_COMMAND_MAILBOX, 32'h0042_0701);
      wr(OFS_COMMAND_STATUS, 32'hffff_ffff);
      wait_ack();
      rd(OFS_COMMAND_MAILBOX, WORD_ZERO);
      rd(OFS_COMMAND_STATUS, 32'h0042_0701);
      rd(OFS_ACK_FLAG_REGISTER, 32'h0000_0001);
      wr(OFS_ACK_FLAG_REGISTER, WORD_ZERO);
      // the line follows the cleared flag one edge later
      @(posedge clk);
      check("ack line", l_ack, 1'h0);
      delay <= 8'h00;
      wr(OFS_COMMAND_MAILBOX, 32'h0000_1a40);
      rd(OFS_COMMAND_STATUS, WORD_ZERO);
      wait_ack();
      rd(OFS_COMMAND_STATUS, 32'h0000_1a41);
      wr(OFS_COMMAND_MAILBOX, WORD_ZERO);
      rd(OFS_COMMAND_MAILBOX, WORD_ZERO);
      wr(OFS_ACK_FLAG_REGISTER, WORD_ZERO);
      $display("mailbox test done");
      wr(OFS_ENGINE_IRQ_ENABLE, 32'hffff_ffff);
      wr(OFS_ENGINE_LINE_SELECT, 32'h0000_0008);
      pulse(32'h0000_0008, 32'h0);
      check("lines", lines, 4'h4);
      rd(OFS_ENGINE_IRQ_FLAGS, 32'h0000_0008);
      wr(OFS_ENGINE_IRQ_FLAGS, ~32'h0000_0008);
      rd(OFS_ENGINE_IRQ_FLAGS, WORD_ZERO);
      check("lines", lines, 4'h0);
      repeat (4) begin
         r = $random(seed);
         pulse(r, 32'h0);
         check("lines", lines[3:2], {|(r & ~32'h8), r[3]});
         wr(OFS_ENGINE_IRQ_FLAGS, 32'hffff_ffff);
         rd(OFS_ENGINE_IRQ_FLAGS, r);
         wr(OFS_ENGINE_IRQ_FLAGS, ~r);
         rd(OFS_ENGINE_IRQ_FLAGS, WORD_ZERO);
      end
      $display("engine test done");
      wr(OFS_HW_IRQ_ENABLE, 32'h0000_0020);
      pulse(32'h0, 32'h0000_0060);
      check("hw line", l_hw, 1'h1);
      rd(OFS_HW_IRQ_FLAGS, 32'h0000_0060);
      wr(OFS_HW_IRQ_FLAGS, ~32'h0000_0020);
      rd(OFS_HW_IRQ_FLAGS, 32'h0000_0040);
      check("hw line", l_hw, 1'h0);
      $display("hardware test done");
      print_verdict();
   end
endmodule // test_radio_command_doorbell
bind rcd_radio_doorbell rcd_doorbell_props #(.ENG_W(ENG_W), .HW_W(HW_W)) rcd_doorbell_props_i (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .cmd_notify(cmd_notify), .cmd_pending(cmd_pending),
   .cmd_word(cmd_word), .cmd_done(cmd_done), .engine_event(engine_event),
   .engine_irq_line_a(engine_irq_line_a), .ack_irq_line(ack_irq_line));
